// ==== rtl/otp_fuse_defines.svh ====
// constants for the one-time-programmable fuse block
`ifndef OTP_FUSE_DEFINES_SVH
`define OTP_FUSE_DEFINES_SVH
`define KEY_W 256
`define USER_W 32
`define UID_W 64
`define CTRL_W 14
`define FAB_ID_W 57
`define FAB_ID_LSB 7
`define IR_W 6
`define IR_KEY 6'h31
`define IR_USER 6'h33
`define IR_CTRL 6'h34
`define CB_AES_ONLY 0
`define CB_EXT_PR_DIS 1
`define CB_WDIS_KEY_USER 2
`define CB_RDIS_KEY 3
`define CB_RDIS_USER 4
`define CB_WDIS_CTRL 5
`define CTRL_USED_MASK 14'h003f
`define SHIFT_W 256
`endif

// ==== rtl/otp_fuse_pkg.sv ====
// types for the one-time-programmable fuse block
`default_nettype none
package otp_fuse_pkg;
  typedef enum logic [3:0] {
    TS_RESET = 4'h0, TS_IDLE = 4'h1, TS_SEL_DR = 4'h2, TS_CAP_DR = 4'h3,
    TS_SH_DR = 4'h4, TS_EX1_DR = 4'h5, TS_PA_DR = 4'h6, TS_EX2_DR = 4'h7,
    TS_UPD_DR = 4'h8, TS_SEL_IR = 4'h9, TS_CAP_IR = 4'ha, TS_SH_IR = 4'hb,
    TS_EX1_IR = 4'hc, TS_PA_IR = 4'hd, TS_EX2_IR = 4'he, TS_UPD_IR = 4'hf
  } tap_state_t;
  typedef struct packed {
    logic aes_only;
    logic ext_pr_dis;
    logic wdis_key_user;
    logic rdis_key;
    logic rdis_user;
    logic wdis_ctrl;
  } ctrl_bits_t;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtag_in_t;
endpackage
`default_nettype wire

// ==== rtl/otp_fuse_access.sv ====
// fuse register set with jtag access and access-control decoding
//
// Operation
// - four fuse registers: 256-bit key, 32-bit user, 64-bit id, 14-bit control.
// - key shifts bit 255 first and feeds the decryptor instead of battery key.
// - user code is 32 bits, shifts bit 0 first, fabric reads it directly.
// - id bits 63:7 form the 57-bit fabric identifier.
// - fabric sees only user code and 57-bit identifier, nothing else.
// - fuse bits only ever go from 0 to 1; disables are permanent.
// - control register programmed and read over jtag, bit 0 first; bits 6-13 reserved.
// - control bit 0 forces fuse key and encrypted-only external bitstreams.
// - with bit 0 clear, bitstream options choose encryption and key source.
// - control bit 1 refuses external partial reconfiguration; internal port still allowed.
// - bit 1 blocks external access after configuration until a documented restart.
// - control bit 2 blocks programming of key and user code.
// - control bit 3 blocks key reading and key and user programming.
// - bit 3 also blocks jtag user read but fabric still sees user code.
// - control bit 4 blocks user reading and key and user programming.
// - control bit 5 blocks further control register programming.
// - key programmable and readable over jtag subject to the access bits.
// - programmed fuse reads 1, pristine fuse reads 0.
// - instruction codes 110001, 110011, 110100 select key, user, control.
`include "otp_fuse_defines.svh"
`default_nettype none
module otp_fuse_access
  import otp_fuse_pkg::*;
#(
  parameter logic [`UID_W-1:0] FACTORY_UID = 64'h0123_4567_89ab_cdef // arbitrary value
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  output logic TDO,
  output logic TDO_OE,
  input wire logic BS_ENCRYPT,
  input wire logic BS_KEY_SEL_FUSE,
  input wire logic CFG_DONE,
  input wire logic RESTART_REQ,
  input wire logic PR_REQ_EXT,
  input wire logic PR_REQ_INTERNAL,
  output logic [`KEY_W-1:0] DECRYPT_KEY,
  output logic USE_FUSE_KEY,
  output logic REQUIRE_ENCRYPTION,
  output logic PR_EXT_ALLOWED,
  output logic PR_INT_ALLOWED,
  output logic EXT_CFG_BLOCKED,
  output logic [`USER_W-1:0] FABRIC_USER_CODE,
  output logic [`FAB_ID_W-1:0] FABRIC_ID,
  output logic PROG_REJECT
);

  // ***************************************************
  // pin synchronisers and tck edge detection
  // ***************************************************
  jtag_in_t sync1_r, sync2_r, sync3_r;
  logic tck_rise, tck_fall;

  // two flops per pin; the third stage only serves the edge finder
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= '{tck: TCK, tms: TMS, tdi: TDI};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end
  assign tck_rise = sync2_r.tck & ~sync3_r.tck;
  assign tck_fall = ~sync2_r.tck & sync3_r.tck;

  // ***************************************************
  // tap controller
  // ***************************************************
  tap_state_t st_r, st_nxt;

  // standard test-port state walk on tms
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      TS_RESET: st_nxt = sync2_r.tms ? TS_RESET : TS_IDLE;
      TS_IDLE: st_nxt = sync2_r.tms ? TS_SEL_DR : TS_IDLE;
      TS_SEL_DR: st_nxt = sync2_r.tms ? TS_SEL_IR : TS_CAP_DR;
      TS_CAP_DR: st_nxt = sync2_r.tms ? TS_EX1_DR : TS_SH_DR;
      TS_SH_DR: st_nxt = sync2_r.tms ? TS_EX1_DR : TS_SH_DR;
      TS_EX1_DR: st_nxt = sync2_r.tms ? TS_UPD_DR : TS_PA_DR;
      TS_PA_DR: st_nxt = sync2_r.tms ? TS_EX2_DR : TS_PA_DR;
      TS_EX2_DR: st_nxt = sync2_r.tms ? TS_UPD_DR : TS_SH_DR;
      TS_UPD_DR: st_nxt = sync2_r.tms ? TS_SEL_DR : TS_IDLE;
      TS_SEL_IR: st_nxt = sync2_r.tms ? TS_RESET : TS_CAP_IR;
      TS_CAP_IR: st_nxt = sync2_r.tms ? TS_EX1_IR : TS_SH_IR;
      TS_SH_IR: st_nxt = sync2_r.tms ? TS_EX1_IR : TS_SH_IR;
      TS_EX1_IR: st_nxt = sync2_r.tms ? TS_UPD_IR : TS_PA_IR;
      TS_PA_IR: st_nxt = sync2_r.tms ? TS_EX2_IR : TS_PA_IR;
      TS_EX2_IR: st_nxt = sync2_r.tms ? TS_UPD_IR : TS_SH_IR;
      TS_UPD_IR: st_nxt = sync2_r.tms ? TS_SEL_DR : TS_IDLE;
      default: st_nxt = TS_RESET;
    endcase
  end

  // state advances on each rising tck edge
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      st_r <= TS_RESET;
    end else if (tck_rise) begin
      st_r <= st_nxt;
    end
  end

  // ***************************************************
  // fuse arrays and control decode
  // ***************************************************
  logic [`KEY_W-1:0] key_fuse_r;
  logic [`USER_W-1:0] user_fuse_r;
  logic [`CTRL_W-1:0] ctrl_fuse_r;
  logic [`UID_W-1:0] uid_fuse;
  ctrl_bits_t cb;

  // factory identifier is never writable from any port
  assign uid_fuse = FACTORY_UID;

  assign cb.aes_only = ctrl_fuse_r[`CB_AES_ONLY];
  assign cb.ext_pr_dis = ctrl_fuse_r[`CB_EXT_PR_DIS];
  assign cb.wdis_key_user = ctrl_fuse_r[`CB_WDIS_KEY_USER];
  assign cb.rdis_key = ctrl_fuse_r[`CB_RDIS_KEY];
  assign cb.rdis_user = ctrl_fuse_r[`CB_RDIS_USER];
  assign cb.wdis_ctrl = ctrl_fuse_r[`CB_WDIS_CTRL];

  // any of bits 2, 3, 4 locks key and user programming
  function automatic logic key_user_wlock(input ctrl_bits_t c);
    key_user_wlock = c.wdis_key_user | c.rdis_key | c.rdis_user;
  endfunction

  // ***************************************************
  // instruction and data shift registers
  // ***************************************************
  logic [`IR_W-1:0] ir_sh_r, ir_r;
  logic [`SHIFT_W-1:0] dr_r;
  logic prog_reject_r;
  logic tdo_r, tdo_oe_r;
  logic sel_key, sel_user, sel_ctrl;

  assign sel_key = (ir_r == `IR_KEY);
  assign sel_user = (ir_r == `IR_USER);
  assign sel_ctrl = (ir_r == `IR_CTRL);

  // instruction path; unknown codes select a one-bit bypass
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ir_sh_r <= '0;
      ir_r <= '0;
    end else if (tck_rise) begin
      if (st_r == TS_RESET) begin
        ir_r <= '0;
      end else if (st_r == TS_CAP_IR) begin
        ir_sh_r <= 6'h01;
      end else if (st_r == TS_SH_IR) begin
        ir_sh_r <= {sync2_r.tdi, ir_sh_r[`IR_W-1:1]};
      end else if (st_r == TS_UPD_IR) begin
        ir_r <= ir_sh_r;
      end
    end
  end

  // data capture and shift; key shifts msb first, others lsb first
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      dr_r <= '0;
    end else if (tck_rise) begin
      if (st_r == TS_CAP_DR) begin
        dr_r <= '0;
        if (sel_key && !cb.rdis_key) begin
          dr_r <= key_fuse_r;
        end else if (sel_user && !cb.rdis_key && !cb.rdis_user) begin
          dr_r[`USER_W-1:0] <= user_fuse_r;
        end else if (sel_ctrl) begin
          dr_r[`CTRL_W-1:0] <= ctrl_fuse_r;
        end
      end else if (st_r == TS_SH_DR) begin
        if (sel_key) begin
          dr_r <= {dr_r[`SHIFT_W-2:0], sync2_r.tdi};
        end else if (sel_user) begin
          dr_r[`USER_W-1:0] <= {sync2_r.tdi, dr_r[`USER_W-1:1]};
        end else if (sel_ctrl) begin
          dr_r[`CTRL_W-1:0] <= {sync2_r.tdi, dr_r[`CTRL_W-1:1]};
        end else begin
          dr_r[0] <= sync2_r.tdi;
        end
      end
    end
  end

  // burning only ORs ones in, so a fuse never returns to zero
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      key_fuse_r <= '0;
      user_fuse_r <= '0;
      ctrl_fuse_r <= '0;
      prog_reject_r <= 1'b0;
    end else if (tck_rise && st_r == TS_UPD_DR) begin
      prog_reject_r <= 1'b0;
      if (sel_key || sel_user) begin
        if (key_user_wlock(cb)) begin
          prog_reject_r <= 1'b1;
        end else if (sel_key) begin
          key_fuse_r <= key_fuse_r | dr_r;
        end else begin
          user_fuse_r <= user_fuse_r | dr_r[`USER_W-1:0];
        end
      end else if (sel_ctrl) begin
        if (cb.wdis_ctrl) begin
          prog_reject_r <= 1'b1;
        end else begin
          ctrl_fuse_r <= ctrl_fuse_r | (dr_r[`CTRL_W-1:0] & `CTRL_USED_MASK);
        end
      end
    end
  end

  // tdo changes on falling tck, driven only in shift states
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_r <= (st_r == TS_SH_DR) || (st_r == TS_SH_IR);
      if (st_r == TS_SH_IR) begin
        tdo_r <= ir_sh_r[0];
      end else if (sel_key) begin
        tdo_r <= dr_r[`SHIFT_W-1];
      end else begin
        tdo_r <= dr_r[0];
      end
    end
  end

  // ***************************************************
  // configuration policy and fabric outputs
  // ***************************************************
  logic ext_lock_r;

  // with control bit 1 set, external block holds from each configuration end until a restart event
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ext_lock_r <= 1'b0;
    end else if (RESTART_REQ) begin
      ext_lock_r <= 1'b0;
    end else if (CFG_DONE && cb.ext_pr_dis) begin
      ext_lock_r <= 1'b1;
    end
  end

  // registered outputs so the fabric sees glitch-free values
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      DECRYPT_KEY <= '0;
      USE_FUSE_KEY <= 1'b0;
      REQUIRE_ENCRYPTION <= 1'b0;
      PR_EXT_ALLOWED <= 1'b0;
      PR_INT_ALLOWED <= 1'b0;
      FABRIC_USER_CODE <= '0;
      FABRIC_ID <= '0;
    end else begin
      // key only leaves toward the decryptor when it is the chosen source
      USE_FUSE_KEY <= cb.aes_only | BS_KEY_SEL_FUSE;
      REQUIRE_ENCRYPTION <= cb.aes_only | BS_ENCRYPT;
      DECRYPT_KEY <= (cb.aes_only | BS_KEY_SEL_FUSE) ? key_fuse_r : '0;
      PR_EXT_ALLOWED <= PR_REQ_EXT & ~cb.ext_pr_dis & ~ext_lock_r;
      PR_INT_ALLOWED <= PR_REQ_INTERNAL;
      FABRIC_USER_CODE <= user_fuse_r;
      FABRIC_ID <= uid_fuse[`UID_W-1:`FAB_ID_LSB];
    end
  end

  assign EXT_CFG_BLOCKED = ext_lock_r;
  assign PROG_REJECT = prog_reject_r;
  assign TDO = tdo_r;
  assign TDO_OE = tdo_oe_r;

endmodule
`default_nettype wire

// ==== sim/otp_fuse_access_sva.sv ====
// assertion checker for the fuse access block
`include "otp_fuse_defines.svh"
`default_nettype none
module otp_fuse_access_sva
  import otp_fuse_pkg::*;
#(
  parameter logic [`UID_W-1:0] FACTORY_UID = 64'h0
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic BS_ENCRYPT,
  input wire logic BS_KEY_SEL_FUSE,
  input wire logic CFG_DONE,
  input wire logic RESTART_REQ,
  input wire logic PR_REQ_EXT,
  input wire logic [`KEY_W-1:0] DECRYPT_KEY,
  input wire logic USE_FUSE_KEY,
  input wire logic REQUIRE_ENCRYPTION,
  input wire logic PR_EXT_ALLOWED,
  input wire logic EXT_CFG_BLOCKED,
  input wire logic [`USER_W-1:0] FABRIC_USER_CODE,
  input wire logic [`FAB_ID_W-1:0] FABRIC_ID
);
  // ****************
  // policy checks
  // ****************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // a restart that no fresh configuration end competes with
  sequence s_restart; RESTART_REQ && !CFG_DONE; endsequence
  sequence s_blocked; EXT_CFG_BLOCKED && !RESTART_REQ; endsequence
  fabric_id_a: assert property (!$past(RST) |-> FABRIC_ID == FACTORY_UID[63:7])
    else $error("fabric id wrong");
  key_hidden_a: assert property (!USE_FUSE_KEY |-> DECRYPT_KEY == '0)
    else $error("fuse key leaks");
  key_select_a: assert property (!$past(RST) && $past(BS_KEY_SEL_FUSE) |-> USE_FUSE_KEY)
    else $error("key choice ignored");
  encrypt_req_a: assert property (!$past(RST) && $past(BS_ENCRYPT) |-> REQUIRE_ENCRYPTION)
    else $error("encryption choice ignored");
  ext_pr_a: assert property (PR_EXT_ALLOWED |-> $past(PR_REQ_EXT))
    else $error("grant without request");
  restart_clear_a: assert property (s_restart |=> !EXT_CFG_BLOCKED)
    else $error("restart left block");
  block_hold_a: assert property (s_blocked |=> EXT_CFG_BLOCKED)
    else $error("block dropped");
  user_otp_a: assert property (!$past(RST) |-> ($past(FABRIC_USER_CODE) & ~FABRIC_USER_CODE) == '0)
    else $error("user fuse cleared");
endmodule
bind otp_fuse_access otp_fuse_access_sva #(.FACTORY_UID(FACTORY_UID)) u_sva (
  .REF_CLK, .RST, .BS_ENCRYPT, .BS_KEY_SEL_FUSE, .CFG_DONE, .RESTART_REQ, .PR_REQ_EXT,
  .DECRYPT_KEY, .USE_FUSE_KEY, .REQUIRE_ENCRYPTION, .PR_EXT_ALLOWED, .EXT_CFG_BLOCKED,
  .FABRIC_USER_CODE, .FABRIC_ID
);
`default_nettype wire

// ==== sim/jtag_host_model.sv ====
// behavioural jtag host that programs and reads the fuse registers
`default_nettype none
module jtag_host_model
  import otp_fuse_pkg::*;
(
  input wire logic clk,
  input wire logic tdo,
  output var jtag_in_t pins
);
  // ****************
  // link tasks
  // ****************
  // idle in test-logic-reset, link clock stands low between frames
  initial pins = 3'h2;
  // one link period is eight system cycles; tdo read just before the rise
  task automatic step(input logic m, input logic d, output logic o);
    pins.tms = m;
    pins.tdi = d;
    repeat (4) @(negedge clk);
    o = tdo;
    pins.tck = 1'b1;
    repeat (4) @(negedge clk);
    pins.tck = 1'b0;
  endtask
  // six-bit instruction, lsb first, back to idle
  task automatic ir(input logic [5:0] c);
    logic o;
    step(0, 0, o); step(1, 0, o); step(1, 0, o); step(0, 0, o); step(0, 0, o);
    for (int i = 0; i < 6; i++) step(i == 5, c[i], o);
    step(1, 0, o); step(0, 0, o);
  endtask
  // data shift; rv sends the top bit first, as the key needs
  task automatic dr(input int n, input bit rv, input logic [255:0] v,
                    output logic [255:0] r);
    int k;
    logic o;
    r = '0;
    step(1, 0, o); step(0, 0, o); step(0, 0, o);
    for (int i = 0; i < n; i++) begin
      k = rv ? n - 1 - i : i;
      step(i == n - 1, v[k], o);
      r[k] = o;
    end
    step(1, 0, o); step(0, 0, o);
  endtask
endmodule
`default_nettype wire

// ==== sim/otp_fuse_access_tb.sv ====
// self-checking testbench for the fuse access block
`include "otp_fuse_defines.svh"
`default_nettype none
module otp_fuse_access_tb
  import otp_fuse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************
  // harness
  // ****************
  localparam logic [63:0] UID = 64'h5a3c_9617_e2d4_0b8f; // arbitrary value
  localparam logic [255:0] KEY = {8'h81, 240'h0, 8'h3c};
  logic clk = 1'b0;
  logic rst, bs_enc, bs_key, cfg_done, restart, pr_ext, pr_int;
  logic tdo, tdo_oe, use_key, req_enc, pr_ext_ok, pr_int_ok, blocked, rej;
  logic [255:0] dec_key, rd;
  logic [31:0] fab_user;
  logic [56:0] fab_id;
  jtag_in_t jt;
  int fails = 0, checks_done = 0, cycles = 0;
  otp_fuse_access #(.FACTORY_UID(UID)) u_dut (
    .REF_CLK(clk), .RST(rst), .TCK(jt.tck), .TMS(jt.tms), .TDI(jt.tdi),
    .TDO(tdo), .TDO_OE(tdo_oe), .BS_ENCRYPT(bs_enc), .BS_KEY_SEL_FUSE(bs_key),
    .CFG_DONE(cfg_done), .RESTART_REQ(restart), .PR_REQ_EXT(pr_ext),
    .PR_REQ_INTERNAL(pr_int), .DECRYPT_KEY(dec_key), .USE_FUSE_KEY(use_key),
    .REQUIRE_ENCRYPTION(req_enc), .PR_EXT_ALLOWED(pr_ext_ok), .PR_INT_ALLOWED(pr_int_ok),
    .EXT_CFG_BLOCKED(blocked), .FABRIC_USER_CODE(fab_user), .FABRIC_ID(fab_id),
    .PROG_REJECT(rej)
  );
  jtag_host_model h (.clk(clk), .tdo(tdo), .pins(jt));
  always #10 clk = ~clk;
  task automatic conclude;
    if (fails == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // a hung shift would stall forever, so cut it off
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic [5:0] c, input int n, input bit rv, input logic [255:0] v);
    h.ir(c);
    h.dr(n, rv, v, rd);
  endtask
  task automatic t_idle;
    logic [1:0] s;
    chk(fab_id, UID[63:7]);
    chk(tdo_oe, 1'b0);
    for (int i = 0; i < 4; i++) begin
      s = i[1:0];
      @(negedge clk) {bs_enc, bs_key, pr_ext, pr_int} = {s, s};
      @(negedge clk) chk({req_enc, use_key, pr_ext_ok, pr_int_ok}, {s, s});
    end
    chk(dec_key, '0);
    {bs_enc, bs_key, pr_ext, pr_int} = 4'h0;
  endtask
  task automatic t_user;
    acc(6'h3f, 2, 1'b0, 256'h1);
    chk(rd, 256'h2);
    acc(`IR_USER, 32, 1'b0, 256'ha5a5_0f0f);
    acc(`IR_USER, 32, 1'b0, 256'hf0f0);
    chk(rd, 256'ha5a5_0f0f);
    acc(`IR_USER, 32, 1'b0, 256'h0);
    chk(rd, 256'ha5a5_ffff);
    chk(fab_user, 32'ha5a5_ffff);
  endtask
  task automatic t_key;
    acc(`IR_KEY, 256, 1'b1, KEY);
    acc(`IR_KEY, 256, 1'b1, 256'h0);
    chk(rd, KEY);
    bs_key = 1'b1;
    @(negedge clk) chk(dec_key, KEY);
    bs_key = 1'b0;
  endtask
  task automatic t_ctrl;
    acc(`IR_CTRL, 14, 1'b0, 256'h3fc3);
    acc(`IR_CTRL, 14, 1'b0, 256'h0);
    chk(rd, 256'h3);
    {pr_ext, pr_int} = 2'h3;
    @(negedge clk) chk({req_enc, use_key, pr_ext_ok, pr_int_ok}, 4'hd);
    chk(dec_key, KEY);
    cfg_done = 1'b1;
    @(negedge clk) cfg_done = 1'b0;
    @(negedge clk) chk(blocked, 1'b1);
    restart = 1'b1;
    @(negedge clk) restart = 1'b0;
    @(negedge clk) chk(blocked, 1'b0);
    {pr_ext, pr_int} = 2'h0;
  endtask
  task automatic t_lock;
    acc(`IR_CTRL, 14, 1'b0, 256'h4);
    acc(`IR_USER, 32, 1'b0, 256'h1);
    chk({rej, fab_user}, {1'b1, 32'ha5a5_ffff});
    acc(`IR_CTRL, 14, 1'b0, 256'h10);
    acc(`IR_USER, 32, 1'b0, 256'h0);
    chk(rd, 256'h0);
    acc(`IR_KEY, 256, 1'b1, 256'h0);
    chk(rd, KEY);
    acc(`IR_CTRL, 14, 1'b0, 256'h8);
    acc(`IR_KEY, 256, 1'b1, 256'h0);
    chk(rd, 256'h0);
    chk({rej, fab_user}, {1'b1, 32'ha5a5_ffff});
    acc(`IR_CTRL, 14, 1'b0, 256'h20);
    chk(rej, 1'b0);
    acc(`IR_CTRL, 14, 1'b0, 256'h1);
    chk({rej, rd[13:0]}, {1'b1, 14'h3f});
  endtask
  initial begin
    {rst, bs_enc, bs_key, cfg_done, restart, pr_ext, pr_int} = 7'h40;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_idle();
    t_user();
    t_key();
    t_ctrl();
    t_lock();
    conclude();
  end
endmodule
`default_nettype wire
